// ### adc_cal_engines.sv
// Converter engines with message-reached internal registers, sample timing
// and calibration correction, one set of state per engine.
// Assumes command messages and raw samples are synchronous to clk_i.
`timescale 1ns/100ps

module adc_cal_engines #(
	parameter int NUM_ENGINES  = 2,  // Converter engines
	parameter int CONV_CLK_DIV = 2,  // System clocks per converter clock
	parameter int RAW_W        = 12  // Raw sample width
) (
	input  wire logic                                 clk_i,          // System clock
	input  wire logic                                 reset_i,        // Sync reset
	input  wire logic                                 cmd_valid_i,    // Message offered
	input  wire logic [31:0]                          cmd_word_i,     // Message word
	output logic                                      cmd_ready_o,    // Message taken
	input  wire logic [NUM_ENGINES-1:0][RAW_W-1:0]    raw_sample_i,   // Converter codes
	output logic      [NUM_ENGINES-1:0]               sampling_o,     // Sampling window
	output logic      [NUM_ENGINES-1:0][7:0]          channel_o,      // Channel selected
	output logic      [NUM_ENGINES-1:0]               upper_ref_o,    // Upper ref chosen
	output logic      [NUM_ENGINES-1:0]               lower_ref_o,    // Lower ref chosen
	output logic      [NUM_ENGINES-1:0]               result_valid_o, // Result strobe
	output adc_cal_pkg::result_t [NUM_ENGINES-1:0]    result_o,       // Result word
	output logic      [NUM_ENGINES-1:0][15:0]         engine_control_o,  // Control reg
	output logic      [NUM_ENGINES-1:0][15:0]         time_stamp_ctl_o,  // Time-stamp reg
	output logic      [NUM_ENGINES-1:0][15:0]         time_base_ctl_o    // Time-base reg
);

	// ==================================================================
	// Elaboration checks, refused before any logic is built
	if (NUM_ENGINES != 2) begin : g_chk_engines
		$error("adc_cal_engines: NUM_ENGINES must be 2");
	end
	// Divider count is 16 bits wide
	if (CONV_CLK_DIV < 1 || CONV_CLK_DIV > 65536) begin : g_chk_div
		$error("adc_cal_engines: CONV_CLK_DIV out of range");
	end
	if (RAW_W != 12) begin : g_chk_raw
		$error("adc_cal_engines: RAW_W must be 12");
	end

	// Engine sequencing states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT,
		ST_DELIVER
	} eng_state_t;

	// ==================================================================
	// Converter clock enable divider
	logic [15:0] div_r;    // Divider count
	logic [15:0] div_nxt;  // Next divider count
	logic        conv_tick; // One-cycle converter clock enable

	assign conv_tick = (div_r == 16'(CONV_CLK_DIV - 1));
	assign div_nxt   = conv_tick ? 16'h0000 : div_r + 16'h0001;

	// Divider register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= div_nxt;
		end
	end

	// ==================================================================
	// Message decode
	logic        cmd_sel;     // Target engine
	logic        cmd_read;    // Read request
	logic [7:0]  cmd_addr;    // Register address
	logic [15:0] cmd_value;   // Write value
	logic        cmd_accept;  // Message taken this cycle
	logic [NUM_ENGINES-1:0] eng_busy; // Engine cannot take a message
	adc_cal_pkg::conv_req_t cmd_conv; // Conversion fields

	assign cmd_sel   = cmd_word_i[adc_cal_pkg::CMD_SEL_BIT];
	assign cmd_read  = cmd_word_i[adc_cal_pkg::CMD_READ_BIT];
	assign cmd_addr  = cmd_word_i[adc_cal_pkg::CMD_ADDR_LSB +: 8];
	assign cmd_value = cmd_word_i[adc_cal_pkg::CMD_VALUE_LSB +: 16];
	assign cmd_conv.cal_en  = cmd_word_i[adc_cal_pkg::CMD_CAL_BIT];
	assign cmd_conv.tag     = cmd_word_i[adc_cal_pkg::CMD_TAG_LSB +: 4];
	assign cmd_conv.sample_time_field     = cmd_word_i[adc_cal_pkg::CMD_LST_LSB +: 2];
	assign cmd_conv.channel = cmd_word_i[adc_cal_pkg::CMD_CHAN_LSB +: 8];

	// Only the addressed engine's busy state stalls the queue
	assign cmd_ready_o = ~eng_busy[cmd_sel];
	assign cmd_accept  = cmd_valid_i & cmd_ready_o;

	// Sample time code to converter clocks, last count index
	function automatic logic [7:0] sample_last(input logic [1:0] code);
		logic [7:0] n;
		n = 8'h00;
		unique case (code)
			2'b00: n = 8'(adc_cal_pkg::SAMPLE_CLKS_00 - 1);
			2'b01: n = 8'(adc_cal_pkg::SAMPLE_CLKS_01 - 1);
			2'b10: n = 8'(adc_cal_pkg::SAMPLE_CLKS_10 - 1);
			2'b11: n = 8'(adc_cal_pkg::SAMPLE_CLKS_11 - 1);
		endcase
		return n;
	endfunction

	// ==================================================================
	// Per-engine registers, sequencer and result
	for (genvar e = 0; e < NUM_ENGINES; e++) begin : g_eng

		// Internal registers of this engine
		logic [15:0] control_r;    // Engine control
		logic [15:0] tstamp_r;     // Time-stamp control
		logic [15:0] tbase_r;      // Time-base control
		logic [14:0] gain_r;       // Own gain constant
		logic [13:0] offset_r;     // Own offset constant
		// Sequencer
		eng_state_t             state_r;   // Current state
		eng_state_t             state_nxt; // Next state
		logic [7:0]             count_r;   // Converter clock count
		logic [7:0]             count_nxt; // Next count
		adc_cal_pkg::conv_req_t req_r;     // Conversion in progress
		logic [RAW_W-1:0]       raw_r;     // Captured raw code
		// Access decode
		logic        hit;       // Message for this engine
		logic        wr_hit;    // Register write
		logic        rd_hit;    // Register read
		logic        conv_hit;  // Conversion start
		logic [15:0] rd_data;   // Read mux output
		logic [13:0] mac_res;   // Corrected result
		// Results
		logic                  res_valid_r; // Result strobe
		adc_cal_pkg::result_t  res_r;       // Result word

		assign hit      = cmd_accept & (cmd_sel == 1'(e));
		assign rd_hit   = hit & cmd_read;
		assign wr_hit   = hit & ~cmd_read;
		assign conv_hit = wr_hit & (cmd_addr == adc_cal_pkg::ADDR_CONVERSION);

		// Busy from a conversion start until its result leaves
		assign eng_busy[e] = (state_r != ST_IDLE);

		// Read mux, reserved bits and addresses read zero
		assign rd_data =
			(cmd_addr == adc_cal_pkg::ADDR_CONTROL)    ? control_r :
			(cmd_addr == adc_cal_pkg::ADDR_TIME_STAMP) ? tstamp_r :
			(cmd_addr == adc_cal_pkg::ADDR_TIME_BASE)  ? tbase_r :
			(cmd_addr == adc_cal_pkg::ADDR_GAIN)       ? {1'b0, gain_r} :
			(cmd_addr == adc_cal_pkg::ADDR_OFFSET)     ? {2'b00, offset_r} :
			16'h0000;

		// Register writes; reserved addresses fall through untouched
		always_ff @(posedge clk_i) begin
			if (reset_i) begin
				control_r <= adc_cal_pkg::CONTROL_RESET;
				tstamp_r  <= adc_cal_pkg::TIME_STAMP_RESET;
				tbase_r   <= adc_cal_pkg::TIME_BASE_RESET;
				gain_r    <= adc_cal_pkg::GAIN_RESET[14:0];
				offset_r  <= adc_cal_pkg::OFFSET_RESET[13:0];
			end else if (wr_hit) begin
				unique case (cmd_addr)
					adc_cal_pkg::ADDR_CONTROL:    control_r <= cmd_value;
					adc_cal_pkg::ADDR_TIME_STAMP: tstamp_r  <= cmd_value;
					adc_cal_pkg::ADDR_TIME_BASE:  tbase_r   <= cmd_value;
					// Bit 0 reserved, integer and fraction kept
					adc_cal_pkg::ADDR_GAIN:
						gain_r <= 15'(cmd_value & adc_cal_pkg::GAIN_MASK);
					// Upper bits of a wide offset are dropped
					adc_cal_pkg::ADDR_OFFSET:
						offset_r <= 14'(cmd_value & adc_cal_pkg::OFFSET_MASK);
					default: ;
				endcase
			end
		end

		// Sequencer next state
		always_comb begin
			state_nxt = state_r;
			count_nxt = count_r;
			unique case (state_r)
				ST_IDLE: begin
					// Wait for a conversion message
					if (conv_hit) begin
						state_nxt = ST_SAMPLE;
						count_nxt = sample_last(cmd_conv.sample_time_field);
					end
				end
				ST_SAMPLE: begin
					// Count sample time in converter clocks
					if (conv_tick) begin
						if (count_r == 8'h00) begin
							state_nxt = ST_CONVERT;
							count_nxt = 8'(adc_cal_pkg::CONVERT_CLKS - 1);
						end else begin
							count_nxt = count_r - 8'h01;
						end
					end
				end
				ST_CONVERT: begin
					// Count conversion time, then take the code
					if (conv_tick) begin
						if (count_r == 8'h00) begin
							state_nxt = ST_DELIVER;
						end else begin
							count_nxt = count_r - 8'h01;
						end
					end
				end
				ST_DELIVER: begin
					// Result goes out, engine free again
					state_nxt = ST_IDLE;
				end
			endcase
		end

		// Sequencer registers
		always_ff @(posedge clk_i) begin
			if (reset_i) begin
				state_r <= ST_IDLE;
				count_r <= 8'h00;
				req_r   <= '0;
				raw_r   <= '0;
			end else begin
				state_r <= state_nxt;
				count_r <= count_nxt;
				if (conv_hit) begin
					req_r <= cmd_conv;
				end
				if (state_r == ST_CONVERT && conv_tick && count_r == 8'h00) begin
					raw_r <= raw_sample_i[e];
				end
			end
		end

		// Gain and offset correction for this engine only
		adc_cal_mac #(
			.RAW_W (RAW_W)
		) u_mac (
			.raw_i    (raw_r),
			.gain_i   (gain_r),
			.offset_i (offset_r),
			.cal_en_i (req_r.cal_en),
			.result_o (mac_res)
		);

		// Result register: read answers and finished conversions
		always_ff @(posedge clk_i) begin
			if (reset_i) begin
				res_valid_r <= 1'b0;
				res_r       <= '0;
			end else if (rd_hit) begin
				res_valid_r <= 1'b1;
				res_r       <= '{queue: cmd_conv.tag, is_read: 1'b1, data: rd_data};
			end else if (state_r == ST_DELIVER) begin
				res_valid_r <= 1'b1;
				// Tag picks the result queue
				res_r       <= '{queue: req_r.tag, is_read: 1'b0,
					data: {2'b00, mac_res}};
			end else begin
				res_valid_r <= 1'b0;
			end
		end

		// Engine outputs
		assign sampling_o[e]       = (state_r == ST_SAMPLE);
		assign channel_o[e]        = req_r.channel;
		assign upper_ref_o[e]      = (req_r.channel == adc_cal_pkg::UPPER_REF_CHANNEL);
		assign lower_ref_o[e]      = (req_r.channel == adc_cal_pkg::LOWER_REF_CHANNEL);
		assign result_valid_o[e]   = res_valid_r;
		assign result_o[e]         = res_r;
		assign engine_control_o[e] = control_r;
		assign time_stamp_ctl_o[e] = tstamp_r;
		assign time_base_ctl_o[e]  = tbase_r;
	end

endmodule // adc_cal_engines

// ### adc_cal_pkg.sv
// Constants, field layouts and carrier types for the converter engine
// register access and calibration block.
// Assumes one 100 MHz clock and a synchronous active-high reset.
//
// Overview of operation
// - Five 16-bit internal registers per engine, message access only
// - Read message returns addressed register as 16-bit word
// - Write message stores its value in register, gain and offset masked
// - Header select bit routes message to one engine
// - Addresses 0x00-0x05 decoded, 0x06-0xFF reserved
// - Gain: bit 0 reserved, bit 1 integer, 2-15 fraction
// - Each engine owns an independent gain register
// - Gain fraction weights two^-1 down to two^-14
// - Offset bits 2-15 signed two's complement, adjusts results
// - Results 14-bit, raw shifted left twice, ideals 0x3000/0x1000
// - Sample time code 0b00 two clocks, 0b10 sixty-four
// - Channel 0x2B upper reference, 0x2C lower reference
// - Select 0 routes to engine 0, tag 0 to queue 0
// - Offset write keeps only low 14 bits
// - Half-LSB of 2 always added to every result
package adc_cal_pkg;

	// ==================================================================
	// Internal register addresses
	localparam logic [7:0] ADDR_CONVERSION  = 8'h00; // Conversion command slot
	localparam logic [7:0] ADDR_CONTROL     = 8'h01; // Engine control
	localparam logic [7:0] ADDR_TIME_STAMP  = 8'h02; // Time-stamp control
	localparam logic [7:0] ADDR_TIME_BASE   = 8'h03; // Time-base control
	localparam logic [7:0] ADDR_GAIN        = 8'h04; // Gain calibration constant
	localparam logic [7:0] ADDR_OFFSET      = 8'h05; // Offset calibration constant

	// ==================================================================
	// Command message field positions (bit 0 is the LSB)
	localparam int CMD_ADDR_LSB  = 0;  // Register address, 8 bits
	localparam int CMD_VALUE_LSB = 8;  // Write value, 16 bits
	localparam int CMD_CHAN_LSB  = 8;  // Conversion channel, 8 bits
	localparam int CMD_LST_LSB   = 18; // Sample time code, 2 bits
	localparam int CMD_TAG_LSB   = 20; // Message tag, 4 bits
	localparam int CMD_CAL_BIT   = 24; // Correction enable
	localparam int CMD_SEL_BIT   = 25; // Converter select bit
	localparam int CMD_READ_BIT  = 26; // Register read request

	// ==================================================================
	// Reset values and field masks (register bit 0 is the MSB)
	localparam logic [15:0] CONTROL_RESET    = 16'h0000;
	localparam logic [15:0] TIME_STAMP_RESET = 16'h0000;
	localparam logic [15:0] TIME_BASE_RESET  = 16'h0000;
	localparam logic [15:0] GAIN_RESET       = 16'h0000;
	localparam logic [15:0] OFFSET_RESET     = 16'h0000;
	localparam logic [15:0] GAIN_MASK        = 16'h7FFF; // Integer + fraction
	localparam logic [15:0] OFFSET_MASK      = 16'h3FFF; // 14-bit signed offset
	localparam int          GAIN_INT_POS     = 14;       // Integer bit
	localparam int          GAIN_FRAC_BITS   = 14;       // Fraction width

	// ==================================================================
	// Sample and conversion timing in converter clocks
	localparam int SAMPLE_CLKS_00 = 2;
	localparam int SAMPLE_CLKS_01 = 8;
	localparam int SAMPLE_CLKS_10 = 64;
	localparam int SAMPLE_CLKS_11 = 128;
	localparam int CONVERT_CLKS   = 13;

	// ==================================================================
	// Result arithmetic and reference channels
	localparam logic [13:0] HALF_LSB_ADD        = 14'h0002;
	localparam logic [13:0] RESULT_MAX          = 14'h3FFF;
	localparam logic [15:0] IDEAL_UPPER_REF_RES = 16'h3000;
	localparam logic [15:0] IDEAL_LOWER_REF_RES = 16'h1000;
	localparam logic [7:0]  UPPER_REF_CHANNEL   = 8'h2B;
	localparam logic [7:0]  LOWER_REF_CHANNEL   = 8'h2C;

	// ==================================================================
	// Carriers
	typedef struct packed {
		logic       cal_en;   // Correction enable
		logic [3:0] tag;      // Message tag
		logic [1:0] sample_time_field;      // Sample time code
		logic [7:0] channel;  // Channel number
	} conv_req_t;

	typedef struct packed {
		logic [3:0]  queue;   // Destination result queue
		logic        is_read; // Register read answer
		logic [15:0] data;    // Result word
	} result_t;

endpackage

// ### adc_cal_mac.sv
// Calibration multiply-accumulate for one converter engine.
// Assumes the raw sample and constants are stable for the cycle used.
`timescale 1ns/100ps

module adc_cal_mac #(
	parameter int RAW_W = 12 // Raw conversion width
) (
	input  wire logic [RAW_W-1:0] raw_i,    // Raw converter code
	input  wire logic [14:0]      gain_i,   // Gain, 1.14 unsigned
	input  wire logic [13:0]      offset_i, // Offset, signed
	input  wire logic             cal_en_i, // Apply gain and offset
	output logic      [13:0]      result_o  // Corrected 14-bit result
);

	// ==================================================================
	// Elaboration checks, refused before any logic is built
	if (RAW_W != 12) begin : g_chk_raw
		$error("adc_cal_mac: RAW_W must be 12");
	end

	logic [13:0] raw14;      // Raw code widened to 14 bits
	logic [28:0] product;    // Gain times raw
	logic [14:0] scaled;     // Product back in 14-bit units
	logic signed [16:0] sum; // Scaled plus offset plus half LSB

	// Raw reads are left shifted twice into 14-bit units
	assign raw14 = {raw_i, 2'b00};

	// Fraction weights two^-1..two^-14 via a 14-bit right shift
	assign product = 29'(gain_i) * 29'(raw14);
	assign scaled  = product[28:14];

	// ==================================================================
	// Half-LSB always added, gain and offset only when correction is enabled
	always_comb begin
		if (cal_en_i) begin
			sum = $signed({2'b00, scaled}) + 17'(signed'(offset_i))
				+ $signed({3'b000, adc_cal_pkg::HALF_LSB_ADD});
		end else begin
			sum = $signed({3'b000, raw14})
				+ $signed({3'b000, adc_cal_pkg::HALF_LSB_ADD});
		end
	end

	// Clamp to the 14-bit result range
	assign result_o = (sum < 0) ? 14'h0000 :
		(sum > $signed({3'b000, adc_cal_pkg::RESULT_MAX})) ?
		adc_cal_pkg::RESULT_MAX : sum[13:0];

endmodule // adc_cal_mac

// ### adc_cal_engines_properties.sv
// Concurrent checks on the converter engine message port and outputs.
// Assumes one clock, synchronous active-high reset, bound to the top module.
`timescale 1ns/100ps

module adc_cal_engines_checker #(
	parameter int NUM_ENGINES = 2 // Converter engines
) (
	input wire logic                              clk_i,            // Clock
	input wire logic                              reset_i,          // Sync reset
	input wire logic                              cmd_valid_i,      // Message offered
	input wire logic [31:0]                       cmd_word_i,       // Message word
	input wire logic                              cmd_ready_o,      // Message taken
	input wire logic [NUM_ENGINES-1:0]            sampling_o,       // Sampling window
	input wire logic [NUM_ENGINES-1:0][7:0]       channel_o,        // Channel selected
	input wire logic [NUM_ENGINES-1:0]            upper_ref_o,      // Upper ref chosen
	input wire logic [NUM_ENGINES-1:0]            lower_ref_o,      // Lower ref chosen
	input wire logic [NUM_ENGINES-1:0]            result_valid_o,   // Result strobe
	input adc_cal_pkg::result_t [NUM_ENGINES-1:0] result_o,         // Result word
	input wire logic [NUM_ENGINES-1:0][15:0]      engine_control_o, // Control reg
	input wire logic [NUM_ENGINES-1:0][15:0]      time_stamp_ctl_o, // Time-stamp reg
	input wire logic [NUM_ENGINES-1:0][15:0]      time_base_ctl_o   // Time-base reg
);
	// ==================================================================
	// Decoded message events
	wire logic take    = cmd_valid_i && cmd_ready_o;              // Message accepted
	wire logic rd_take = take && cmd_word_i[26];                  // Register read
	wire logic wr_take = take && !cmd_word_i[26] && |cmd_word_i[7:0]; // Register write
	wire logic cv_take = take && !cmd_word_i[26] && !(|cmd_word_i[7:0]); // Conversion

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// ==================================================================
	// Properties
	a_read_answer_tag: assert property (rd_take && !cmd_word_i[25] |=>
		result_valid_o[0] && result_o[0].is_read && result_o[0].queue == $past(cmd_word_i[23:20]))
		else $error("read answer missing or mistagged");
	a_reserved_read_zero: assert property (rd_take && !cmd_word_i[25] &&
		cmd_word_i[7:0] > 8'h05 |=> result_o[0].data == 16'h0000)
		else $error("reserved read not zero");
	a_control_write_store: assert property (wr_take && !cmd_word_i[25] &&
		cmd_word_i[7:0] == 8'h01 |=> engine_control_o[0] == $past(cmd_word_i[23:8]))
		else $error("control write not stored");
	a_other_engine_kept: assert property (wr_take && cmd_word_i[25] |=>
		$stable(engine_control_o[0]) && $stable(time_stamp_ctl_o[0]) && $stable(time_base_ctl_o[0]))
		else $error("write reached the other engine");
	a_reserved_write_none: assert property (wr_take && cmd_word_i[7:0] > 8'h05 |=>
		$stable(engine_control_o) && $stable(time_stamp_ctl_o) && $stable(time_base_ctl_o))
		else $error("reserved write changed state");
	a_ref_channel_decode: assert property ((upper_ref_o[0] == (channel_o[0] == 8'h2B)) &&
		(lower_ref_o[0] == (channel_o[0] == 8'h2C)))
		else $error("reference channel decode wrong");
	a_sampling_starts: assert property (cv_take && !cmd_word_i[25] |-> ##[1:4] sampling_o[0])
		else $error("sampling did not start");
	a_conv_result_due: assert property (cv_take && !cmd_word_i[25] |->
		##[15:400] result_valid_o[0])
		else $error("conversion result not delivered");
	a_result_range: assert property (result_valid_o[0] && !result_o[0].is_read |->
		result_o[0].data[15:14] == 2'b00)
		else $error("result exceeds 14 bits");
endmodule // adc_cal_engines_checker

bind adc_cal_engines adc_cal_engines_checker #(.NUM_ENGINES(NUM_ENGINES)) u_checker (
	.clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_word_i(cmd_word_i),
	.cmd_ready_o(cmd_ready_o), .sampling_o(sampling_o), .channel_o(channel_o),
	.upper_ref_o(upper_ref_o), .lower_ref_o(lower_ref_o), .result_valid_o(result_valid_o),
	.result_o(result_o), .engine_control_o(engine_control_o),
	.time_stamp_ctl_o(time_stamp_ctl_o), .time_base_ctl_o(time_base_ctl_o));

// ### cmd_queue_model.sv
// Behavioural command queue controller offering one message at a time.
// Assumes the bench raises go_i for one cycle with word_i settled.
`timescale 1ns/100ps

module cmd_queue_model (
	input  wire logic        clk_i,       // Clock
	input  wire logic        go_i,        // Start a message
	input  wire logic [31:0] word_i,      // Message to offer
	input  wire logic        cmd_ready_i, // Engine accepts
	output logic             cmd_valid_o, // Message offered
	output logic      [31:0] cmd_word_o,  // Message word
	output logic             done_o       // Message was taken
);
	// Idle bus at time zero
	initial begin
		cmd_valid_o = 1'b0;
		cmd_word_o = 32'h00000000;
		done_o = 1'b0;
	end

	// Hold the word until taken, then scramble the released bus
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (cmd_valid_o && cmd_ready_i) begin
			cmd_valid_o <= 1'b0;
			cmd_word_o <= ~cmd_word_o;
			done_o <= 1'b1;
		end else if (go_i && !cmd_valid_o) begin
			cmd_valid_o <= 1'b1;
			cmd_word_o <= word_i;
		end
	end
endmodule // cmd_queue_model

// ### tb_adc_cal_engines.sv
// Self-checking bench for the converter engine register and calibration block.
// Assumes the queue model and the bound checker are compiled beforehand.
`timescale 1ns/100ps

module tb_adc_cal_engines;
	logic                       clk_i = 1'b0;       // Clock
	logic                       reset_i = 1'b1;     // Reset
	logic                       go = 1'b0;          // Message request
	logic [31:0]                word = 32'h00000000; // Message to send
	logic [1:0][11:0]           raw = 24'h000000;   // Raw codes
	logic                       valid, ready, done; // Handshake
	logic [31:0]                cmd;                // Bus word
	logic [1:0]                 smp, rv, up, lo;    // Per-engine flags
	logic [1:0][7:0]            ch;                 // Channels
	adc_cal_pkg::result_t [1:0] res;                // Results
	logic [1:0][15:0]           ctl, tsc, tbc;      // Register outputs
	int                         num_errors = 0;     // Mismatches
	int                         n_checks = 0;       // Comparisons
	int                         samp_cnt = 0;       // Sampling cycles

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) if (|smp) samp_cnt++;

	// ==================================================================
	// Block and far side
	adc_cal_engines #(.NUM_ENGINES(2), .CONV_CLK_DIV(1), .RAW_W(12)) dut (
		.clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(valid), .cmd_word_i(cmd),
		.cmd_ready_o(ready), .raw_sample_i(raw), .sampling_o(smp), .channel_o(ch),
		.upper_ref_o(up), .lower_ref_o(lo), .result_valid_o(rv), .result_o(res),
		.engine_control_o(ctl), .time_stamp_ctl_o(tsc), .time_base_ctl_o(tbc));
	cmd_queue_model ctrl (.clk_i(clk_i), .go_i(go), .word_i(word), .cmd_ready_i(ready),
		.cmd_valid_o(valid), .cmd_word_o(cmd), .done_o(done));

	// ==================================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic send(input logic [31:0] w);
		int k;
		word = w;
		go = 1'b1;
		@(posedge clk_i);
		#1 go = 1'b0;
		for (k = 0; k < 400 && done !== 1'b1; k++) begin
			@(posedge clk_i);
			#1;
		end
		check("handshake", done, 1'b1);
	endtask
	task automatic rd(input logic sel, input logic [7:0] addr, input logic [15:0] exp);
		send({5'h00, 1'b1, sel, 1'b0, 4'h5, 12'h000, addr});
		check("read answer", {rv[sel], res[sel]}, {1'b1, 4'h5, 1'b1, exp});
	endtask
	task automatic wr(input logic sel, input logic [7:0] addr, input logic [15:0] v);
		send({5'h00, 1'b0, sel, 1'b0, v, addr});
	endtask
	task automatic conv(input logic [31:0] w, input logic [15:0] exp, input int samp);
		int k;
		samp_cnt = 0;
		send(w);
		for (k = 0; k < 400 && rv[w[25]] !== 1'b1; k++) begin
			@(posedge clk_i);
			#1;
		end
		check("conversion", {rv[w[25]], res[w[25]]}, {1'b1, w[23:20], 1'b0, exp});
		check("sample clocks", samp_cnt, samp);
	endtask

	// ==================================================================
	// Scenarios
	task automatic t_reset_values();
		for (int a = 0; a < 6; a++) begin
			rd(1'b0, a[7:0], 16'h0000);
			rd(1'b1, a[7:0], 16'h0000);
		end
		$display("test reset_values done");
	endtask
	task automatic t_regs();
		logic [15:0] v;
		for (int a = 1; a < 4; a++) begin
			for (int s = 0; s < 2; s++) begin
				v = 16'h5A00 | 16'(a * 16 + s);
				wr(s[0], a[7:0], v);
				rd(s[0], a[7:0], v);
			end
		end
		check("control 0", ctl[0], 16'h5A10);
		check("control 1", ctl[1], 16'h5A11);
		check("time stamp 1", tsc[1], 16'h5A21);
		check("time base 0", tbc[0], 16'h5A30);
		$display("test regs done");
	endtask
	task automatic t_fields();
		wr(1'b0, 8'h04, 16'hFFFF);
		rd(1'b0, 8'h04, 16'h7FFF);
		wr(1'b0, 8'h05, 16'hFFFF);
		rd(1'b0, 8'h05, 16'h3FFF);
		rd(1'b1, 8'h04, 16'h0000);
		$display("test fields done");
	endtask
	task automatic t_reserved();
		wr(1'b0, 8'h06, 16'hFFFF);
		wr(1'b0, 8'hFF, 16'hFFFF);
		rd(1'b0, 8'h06, 16'h0000);
		rd(1'b0, 8'hFF, 16'h0000);
		rd(1'b0, 8'h01, 16'h5A10);
		rd(1'b0, 8'h04, 16'h7FFF);
		$display("test reserved done");
	endtask
	task automatic t_raw_refs();
		raw = {12'h000, 12'hC00};
		conv(32'h00002B00, 16'h3002, 2);
		check("upper ref", {up[0], lo[0]}, 2'b10);
		check("channel", ch[0], 8'h2B);
		raw = {12'h000, 12'h400};
		conv(32'h00082C00, 16'h1002, 64);
		check("lower ref", {up[0], lo[0]}, 2'b01);
		$display("test raw_refs done");
	endtask
	task automatic t_calibrated();
		wr(1'b1, 8'h04, 16'h2000);
		wr(1'b1, 8'h05, 16'h0005);
		raw = {12'hC00, 12'h400};
		conv(32'h03202B00, 16'h1807, 2);
		conv(32'h01002B00, 16'h2000, 2);
		$display("test calibrated done");
	endtask
	task automatic t_busy();
		int k;
		raw = {12'h000, 12'h123};
		send(32'h00082C00);
		rd(1'b1, 8'h01, 16'h5A11);
		check("sampling", smp[0], 1'b1);
		// Read to the busy engine is offered and must stall
		word = {5'h00, 1'b1, 1'b0, 1'b0, 4'h5, 12'h000, 8'h01};
		go = 1'b1;
		@(posedge clk_i);
		#1 go = 1'b0;
		check("busy ready", ready, 1'b0);
		for (k = 0; k < 400 && rv[0] !== 1'b1; k++) begin
			@(posedge clk_i);
			#1;
		end
		check("busy conversion", {rv[0], res[0]}, {1'b1, 4'h0, 1'b0, 16'h048E});
		rd(1'b0, 8'h01, 16'h5A10);
		$display("test busy done");
	endtask

	// ==================================================================
	// Verdict
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		#1 reset_i = 1'b0;
		t_reset_values();
		t_regs();
		t_fields();
		t_reserved();
		t_raw_refs();
		t_calibrated();
		t_busy();
		wrap_up();
	end

	// Watchdog
	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end
endmodule // tb_adc_cal_engines
